/* File: rtl/pdi_peak_irq.v */
// Notes on behaviour
// R1 - watch current and voltage peaks together
// R2 - voltage over its threshold sets voltage flag
// R3 - current over its threshold sets current flag
// R4 - thresholds compare against doubled sample magnitude
// R5 - peak events reach irq only when enabled
// R6 - peak records keep the largest magnitude
// R7 - voltage record doubled, current record plain
// R8 - clear-on-read aliases zero records after read
// R9 - status flags set regardless of enables
// R10 - irq low while enabled flag is set
// R11 - host reads status with reset, flags clear
// R12 - irq high from command end to data end
// R13 - events during that read stay pending
// R14 - host takes irq on falling edge
// R15 - host masks, clears flag, then reads status; the host model never masks, it only clears its flag and reads
// R16 - mode bit five starts temperature at crossing
// R17 - temperature result lands 96 clocks later
// R18 - finished conversion raises irq when enabled
// R19 - temperature is signed byte, uncalibrated
// R20 - modulators sampled at quarter master clock
// R21 - status read restores flags and irq defaults
// R22 - crossing level follows sign, both edges trigger
// R23 - upper byte of doubled magnitude, strictly greater
// R24 - flags set by events, set beats clear
`include "pdi_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module pdi_peak_irq (
   input  wire        core_clk_in,        // master clock, 10 MHz
   input  wire        reset_n_in,         // asynchronous, active low
   input  wire        serial_clk_in,      // host serial clock pin
   input  wire        serial_sel_n_in,    // host chip select, low active
   input  wire        serial_din_in,      // host data into device
   input  wire [23:0] current_sample_in,  // signed filter word, channel 1
   input  wire [23:0] voltage_sample_in,  // signed filter word, channel 2
   input  wire        sample_valid_in,    // one-cycle strobe, both words
   input  wire [7:0]  temp_code_in,       // processed sensor code
   output reg         serial_dout_out,    // data to host
   output reg         serial_dout_oe_out, // high while driving dout
   output reg         irq_n_out,          // open-drain level, always low
   output reg         irq_oe_out,         // high while pulling irq low
   output reg         line_zero_crossing_out, // crossing level
   output reg         temp_route_out,     // sensor routed to channel 1
   output reg         mod_sample_tick_out // one pulse every four clocks
);
   // state codes of the serial engine
   localparam ST_CMD  = 1'b0;
   localparam ST_DATA = 1'b1;
   reg         rst_a_r, rst_n_r;        // reset release chain
   wire [2:0]  pins_s;                  // synchronised serial pins
   reg         sclk_d_r;                // previous synchronised clock
   reg         state_r;                 // serial engine state
   reg  [4:0]  bit_cnt_r;               // bits seen in this phase
   reg  [4:0]  data_bits_r;             // bits in the data phase
   reg  [7:0]  cmd_r;                   // command byte being shifted
   reg  [23:0] in_sh_r;                 // write data being shifted
   reg  [23:0] out_sh_r;                // read data being shifted
   reg         status_hold_r;           // irq released during status-with-reset read
   reg  [15:0] status_snap_r;           // flags reported by the read
   reg  [15:0] mode_r;                  // operating mode
   reg  [15:0] irq_mask_r;              // interrupt enable mask
   reg  [15:0] status_r;                // interrupt status flags
   reg  [7:0]  vpk_thr_r;               // voltage peak threshold
   reg  [7:0]  ipk_thr_r;               // current peak threshold
   reg  [23:0] ipk_rec_r;               // current peak record
   reg  [23:0] vpk_rec_r;               // voltage peak record
   reg  [7:0]  temp_r;                  // die temperature result
   reg         temp_busy_r;             // conversion running
   reg  [6:0]  temp_cnt_r;              // cycles left in conversion
   reg  [1:0]  mod_div_r;               // quarter-rate divider
   reg         ev_temp;                 // conversion done this cycle

   wire sclk_s  = pins_s[0];
   wire sel_s   = ~pins_s[1];           // selected, active high
   wire din_s   = pins_s[2];
   wire sclk_rise = sclk_s & ~sclk_d_r;
   wire sclk_fall = ~sclk_s & sclk_d_r;
   // magnitude of a signed word
   function [23:0] abs24;
      input [23:0] s;
      begin
         abs24 = s[23] ? (~s + 24'h000001) : s;
      end
   endfunction
   // doubled magnitude, saturating at the top of 24 bits
   function [23:0] dbl24;
      input [23:0] m;
      begin
         dbl24 = m[23] ? 24'hffffff : {m[22:0], 1'b0};
      end
   endfunction
   // number of data bits carried by a register address
   function [4:0] reg_bits;
      input [5:0] a;
      begin
         case (a)
            `PDI_ADDR_MODE, `PDI_ADDR_IRQ_MASK, `PDI_ADDR_STATUS,
            `PDI_ADDR_STATUS_RC:
               reg_bits = 5'd16;
            `PDI_ADDR_IPK_REC, `PDI_ADDR_IPK_REC_RC, `PDI_ADDR_VPK_REC,
            `PDI_ADDR_VPK_REC_RC:
               reg_bits = 5'd24;
            default:
               reg_bits = 5'd8;
         endcase
      end
   endfunction
   // read value, left justified so its top bit leaves first
   function [23:0] rd_value;
      input [5:0] a;
      begin
         case (a)
            `PDI_ADDR_MODE:       rd_value = {mode_r, 8'h00};
            `PDI_ADDR_IRQ_MASK:   rd_value = {irq_mask_r, 8'h00};
            `PDI_ADDR_STATUS,
            `PDI_ADDR_STATUS_RC:  rd_value = {status_r, 8'h00};
            `PDI_ADDR_IPK_THR:    rd_value = {ipk_thr_r, 16'h0000};
            `PDI_ADDR_VPK_THR:    rd_value = {vpk_thr_r, 16'h0000};
            `PDI_ADDR_IPK_REC,
            `PDI_ADDR_IPK_REC_RC: rd_value = ipk_rec_r;
            `PDI_ADDR_VPK_REC,
            `PDI_ADDR_VPK_REC_RC: rd_value = vpk_rec_r;
            `PDI_ADDR_TEMP:       rd_value = {temp_r, 16'h0000};
            default:              rd_value = 24'h000000;
         endcase
      end
   endfunction
   // magnitudes and comparisons on the incoming words
   wire [23:0] imag = abs24(current_sample_in);
   wire [23:0] vmag = abs24(voltage_sample_in);
   wire [23:0] idbl = dbl24(imag);
   wire [23:0] vdbl = dbl24(vmag);
   wire ev_pki = sample_valid_in & (idbl[23:16] > ipk_thr_r); // R1 R3 R4 R23
   wire ev_pkv = sample_valid_in & (vdbl[23:16] > vpk_thr_r); // R1 R2 R4 R23
   wire zx_now = ~voltage_sample_in[23];       // positive half high
   wire zx_edge = sample_valid_in & (zx_now != line_zero_crossing_out);
   // transfer-level decodes, void once select has dropped
   wire       is_write  = cmd_r[`PDI_CMD_WRITE_BIT];
   wire [5:0] addr      = cmd_r[5:0];
   wire       data_done = sel_s & (state_r == ST_DATA) & sclk_fall &
                          (bit_cnt_r == data_bits_r - 5'd1);
   wire       rd_done   = data_done & ~is_write;
   wire [23:0] wr_word  = {in_sh_r[22:0], din_s};

   // event vector, one bit per flag; conversion ends on the last count
   reg [15:0] ev_vec;
   always @* begin
      ev_temp = temp_busy_r & (temp_cnt_r == 7'd1);
      ev_vec = 16'h0000;
      ev_vec[`PDI_ST_PKI_BIT]  = ev_pki;
      ev_vec[`PDI_ST_PKV_BIT]  = ev_pkv;
      ev_vec[`PDI_ST_TEMP_BIT] = ev_temp;
   end

   // reset release: asynchronous entry, two-flop exit
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_a_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_n_r <= rst_a_r;
      end
   end

   // serial pins cross into the clock domain, select resets idle high
   pdi_sync2 #(.W(3), .RST(3'b010)) u_sync (
      .clk_in   (core_clk_in),
      .rst_n_in (rst_n_r),
      .async_in ({serial_din_in, serial_sel_n_in, serial_clk_in}),
      .sync_out (pins_s)
   );

   // serial engine: data in on falling edges, out on rising edges
   always @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sclk_d_r        <= 1'b0;
         state_r         <= ST_CMD;
         bit_cnt_r       <= 5'd0;
         data_bits_r     <= 5'd8;
         cmd_r           <= 8'h00;
         in_sh_r         <= 24'h000000;
         out_sh_r        <= 24'h000000;
         status_hold_r   <= 1'b0;
         status_snap_r   <= 16'h0000;
         serial_dout_out <= 1'b0;
         serial_dout_oe_out <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
         serial_dout_oe_out <= sel_s;
         if (!sel_s) begin
            // deselect aborts any transfer and frees irq
            state_r       <= ST_CMD;
            bit_cnt_r     <= 5'd0;
            status_hold_r <= 1'b0;
         end else begin
            case (state_r)
               ST_CMD: begin
                  if (sclk_fall) begin
                     cmd_r     <= {cmd_r[6:0], din_s};
                     bit_cnt_r <= bit_cnt_r + 5'd1;
                     if (bit_cnt_r == 5'd7) begin
                        state_r     <= ST_DATA;
                        bit_cnt_r   <= 5'd0;
                        data_bits_r <= reg_bits({cmd_r[4:0], din_s});
                        out_sh_r    <= rd_value({cmd_r[4:0], din_s});
                        // release irq on last fall of command byte
                        if (!cmd_r[6] &&
                            {cmd_r[4:0], din_s} == `PDI_ADDR_STATUS_RC) begin
                           status_hold_r <= 1'b1;      // R11 R12
                           status_snap_r <= status_r;  // R11
                        end
                     end
                  end
               end
               ST_DATA: begin
                  if (sclk_rise && !is_write) begin
                     serial_dout_out <= out_sh_r[23];
                     out_sh_r        <= {out_sh_r[22:0], 1'b0};
                  end
                  if (sclk_fall) begin
                     in_sh_r   <= wr_word;
                     bit_cnt_r <= bit_cnt_r + 5'd1;
                     if (data_done) begin
                        // irq may fall again once data is out
                        state_r       <= ST_CMD;  // R12 R13
                        bit_cnt_r     <= 5'd0;
                        status_hold_r <= 1'b0;    // R12 R13
                     end
                  end
               end
               default: begin
                  state_r   <= ST_CMD;
                  bit_cnt_r <= 5'd0;
               end
            endcase
         end
      end
   end

   // control registers written by the host
   always @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mode_r     <= `PDI_MODE_RST;
         irq_mask_r <= `PDI_MASK_RST;
         vpk_thr_r  <= `PDI_THR_RST;
         ipk_thr_r  <= `PDI_THR_RST;
      end else begin
         if (data_done && is_write) begin
            case (addr)
               `PDI_ADDR_MODE:     mode_r     <= wr_word[15:0];
               `PDI_ADDR_IRQ_MASK: irq_mask_r <= wr_word[15:0];
               `PDI_ADDR_VPK_THR:  vpk_thr_r  <= wr_word[7:0];
               `PDI_ADDR_IPK_THR:  ipk_thr_r  <= wr_word[7:0];
               default: ;
            endcase
         end
         // mode bit five is consumed by the crossing that starts it
         if (zx_edge && mode_r[`PDI_MODE_TEMP_BIT] && !temp_busy_r)
            mode_r[`PDI_MODE_TEMP_BIT] <= 1'b0;  // R16
      end
   end

   // status flags: events set, status-with-reset read clears
   always @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         status_r <= 16'h0000;
      end else if (rd_done && addr == `PDI_ADDR_STATUS_RC) begin
         status_r <= (status_r & ~status_snap_r) | ev_vec; // R21 R24 R13
      end else begin
         status_r <= status_r | ev_vec;                    // R9 R24
      end
   end

   // open-drain irq: pull low on any enabled flag outside a status-with-reset read
   always @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_n_out  <= 1'b0;
         irq_oe_out <= 1'b0;
      end else begin
         irq_n_out  <= 1'b0;
         irq_oe_out <= (|(status_r & irq_mask_r)) & ~status_hold_r; // R5 R10 R18 R12
      end
   end

   // peak records track the largest magnitude, cleared by alias reads
   always @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ipk_rec_r <= `PDI_REC_RST;
         vpk_rec_r <= `PDI_REC_RST;
      end else begin
         if (sample_valid_in && imag > ipk_rec_r)
            ipk_rec_r <= imag;                                 // R6 R7
         else if (rd_done && addr == `PDI_ADDR_IPK_REC_RC)
            ipk_rec_r <= `PDI_REC_RST;                         // R8
         if (sample_valid_in && vdbl > vpk_rec_r)
            vpk_rec_r <= vdbl;                                 // R6 R7
         else if (rd_done && addr == `PDI_ADDR_VPK_REC_RC)
            vpk_rec_r <= `PDI_REC_RST;                         // R8
      end
   end

   // crossing level and temperature conversion sequence
   always @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         line_zero_crossing_out <= 1'b0;
         temp_busy_r    <= 1'b0;
         temp_cnt_r     <= 7'd0;
         temp_route_out <= 1'b0;
         temp_r         <= `PDI_TEMP_RST;
      end else begin
         if (sample_valid_in)
            line_zero_crossing_out <= zx_now;           // R22
         if (zx_edge && mode_r[`PDI_MODE_TEMP_BIT] && !temp_busy_r) begin
            temp_busy_r    <= 1'b1;                     // R16 R22
            temp_route_out <= 1'b1;                     // R16
            temp_cnt_r     <= `PDI_TEMP_DELAY_CYC;      // R17
         end else if (temp_busy_r) begin
            temp_cnt_r <= temp_cnt_r - 7'd1;
            if (ev_temp) begin
               temp_busy_r    <= 1'b0;
               temp_route_out <= 1'b0;
               temp_r         <= temp_code_in;          // R17 R19
            end
         end
      end
   end

   // modulator sampling tick at a quarter of the master clock
   always @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mod_div_r           <= 2'd0;
         mod_sample_tick_out <= 1'b0;
      end else begin
         mod_div_r           <= mod_div_r + 2'd1;
         mod_sample_tick_out <= (mod_div_r == `PDI_MOD_DIV); // R20
      end
   end
endmodule
`default_nettype wire

/* File: rtl/pdi_regs.vh */
`ifndef PDI_REGS_VH
`define PDI_REGS_VH
// register addresses, six-bit field of the command byte
`define PDI_ADDR_MODE        6'h09
`define PDI_ADDR_IRQ_MASK    6'h0a
`define PDI_ADDR_STATUS      6'h0b
`define PDI_ADDR_STATUS_RC   6'h0c
`define PDI_ADDR_IPK_THR     6'h20
`define PDI_ADDR_VPK_THR     6'h21
`define PDI_ADDR_IPK_REC     6'h22
`define PDI_ADDR_IPK_REC_RC  6'h23
`define PDI_ADDR_VPK_REC     6'h24
`define PDI_ADDR_VPK_REC_RC  6'h25
`define PDI_ADDR_TEMP        6'h26
// command byte fields
`define PDI_CMD_WRITE_BIT    7
// mode register fields
`define PDI_MODE_TEMP_BIT    5
// status and mask bit positions
`define PDI_ST_TEMP_BIT      5
`define PDI_ST_PKI_BIT       8
`define PDI_ST_PKV_BIT       9
// reset values
`define PDI_MODE_RST         16'h0000
`define PDI_MASK_RST         16'h0000
`define PDI_THR_RST          8'hff
`define PDI_REC_RST          24'h000000
`define PDI_TEMP_RST         8'h00
// temperature result is ready this many master clock periods after
// the triggering zero crossing
`define PDI_TEMP_DELAY_CLK   96
`define PDI_TEMP_DELAY_CYC   7'd96
// modulator sample tick fires when the divider reaches this count, once every four master clocks
`define PDI_MOD_DIV          2'd3
`endif

/* File: rtl/pdi_sync2.v */
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for a group of asynchronous levels
module pdi_sync2 #(
   parameter         W   = 3,
   parameter [W-1:0] RST = {W{1'b0}}  // idle level of each pin
) (
   input  wire         clk_in,
   input  wire         rst_n_in,
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta_r;  // first stage, read only by the second
         reg sync_r;  // second stage, safe to use
         // both stages take the pin's idle level under reset, so no
         // false edge or false select follows the release
         always @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               meta_r <= RST[i];
               sync_r <= RST[i];
            end else begin
               meta_r <= async_in[i];
               sync_r <= meta_r;
            end
         end
         assign sync_out[i] = sync_r;
      end
   endgenerate
endmodule
`default_nettype wire

/* File: test/pdi_peak_irq_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// pin-level watch on the event block
module pdi_peak_chk (
   input wire logic        core_clk_in,
   input wire logic        reset_n_in,
   input wire logic        serial_clk_in,
   input wire logic        serial_sel_n_in,
   input wire logic        serial_din_in,
   input wire logic [23:0] current_sample_in,
   input wire logic [23:0] voltage_sample_in,
   input wire logic        sample_valid_in,
   input wire logic [7:0]  temp_code_in,
   input wire logic        serial_dout_out,
   input wire logic        serial_dout_oe_out,
   input wire logic        irq_n_out,
   input wire logic        irq_oe_out,
   input wire logic        line_zero_crossing_out,
   input wire logic        temp_route_out,
   input wire logic        mod_sample_tick_out
);
   logic [7:0] route_cnt_r; // cycles the sensor stays routed
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   // length of each conversion
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         route_cnt_r <= 8'h00;
      else if (temp_route_out)
         route_cnt_r <= route_cnt_r + 8'h01;
      else
         route_cnt_r <= 8'h00;
   end
   a_irq_open_drain: assert property (irq_n_out == 1'b0)
      else $error("irq data level not low");
   a_tick_quarter: assert property (mod_sample_tick_out |=>
      !mod_sample_tick_out [*3] ##1 mod_sample_tick_out)
      else $error("modulator tick not one in four");
   a_zx_follow: assert property (sample_valid_in |=>
      line_zero_crossing_out == !$past(voltage_sample_in[23]))
      else $error("crossing level does not follow sign");
   a_zx_hold: assert property (!sample_valid_in |=>
      $stable(line_zero_crossing_out))
      else $error("crossing level moved without sample");
   a_temp_span: assert property ($fell(temp_route_out) |->
      route_cnt_r inside {[95:96]})
      else $error("conversion length wrong");
   a_route_start: assert property ($rose(temp_route_out) |->
      $past(sample_valid_in) || $past(sample_valid_in, 2))
      else $error("conversion started without sample");
   a_irq_cause: assert property ($rose(irq_oe_out) |->
      $past(sample_valid_in, 2) || $past(temp_route_out, 2) ||
      $past(!serial_sel_n_in, 8))
      else $error("irq asserted without cause");
   a_irq_idle: assert property ((serial_sel_n_in && !sample_valid_in &&
      !temp_route_out) [*4] |=> $stable(irq_oe_out))
      else $error("irq moved while idle");
   a_oe_desel: assert property (serial_sel_n_in [*4] |=>
      !serial_dout_oe_out)
      else $error("data driven while deselected");
   c_temp_done: cover property ($fell(temp_route_out));
   c_irq_low: cover property ($rose(irq_oe_out));
   c_irq_rel: cover property ($fell(irq_oe_out) && !serial_sel_n_in);
endmodule
bind pdi_peak_irq pdi_peak_chk pdi_peak_chk_i (
   .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
   .serial_clk_in(serial_clk_in), .serial_sel_n_in(serial_sel_n_in),
   .serial_din_in(serial_din_in), .current_sample_in(current_sample_in),
   .voltage_sample_in(voltage_sample_in),
   .sample_valid_in(sample_valid_in), .temp_code_in(temp_code_in),
   .serial_dout_out(serial_dout_out),
   .serial_dout_oe_out(serial_dout_oe_out), .irq_n_out(irq_n_out),
   .irq_oe_out(irq_oe_out),
   .line_zero_crossing_out(line_zero_crossing_out),
   .temp_route_out(temp_route_out),
   .mod_sample_tick_out(mod_sample_tick_out));
`default_nettype wire

/* File: test/pdi_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// host side of the serial link and of the pulled-up irq wire
module pdi_host_model (
   input  wire logic dout_in,
   input  wire logic dout_oe_in,
   input  wire logic irq_n_in,
   input  wire logic irq_oe_in,
   output var  logic sclk_out,
   output var  logic sel_n_out,
   output var  logic din_out,
   output wire logic irq_level_out,
   output var  logic irq_seen_out
);
   wire dout_w; // data wire level seen by the host
   // an undriven data wire never shows a clean stale bit
   assign dout_w = dout_oe_in ? dout_in : ~dout_in;
   assign irq_level_out = irq_oe_in ? irq_n_in : 1'b1; // pull-up
   initial begin
      sclk_out = 1'b0;
      sel_n_out = 1'b1;
      din_out = 1'b0;
      irq_seen_out = 1'b0;
   end
   // interrupt taken on the falling edge of the wire
   always @(negedge irq_level_out) irq_seen_out = 1'b1;
   // one bit: device takes din on the fall, host reads late low
   task automatic bit_x(input logic b, output logic r);
      din_out = b;
      #10 sclk_out = 1'b1;
      #400 sclk_out = 1'b0;
      #380 r = dout_w;
      #10;
   endtask
   // one frame, command byte then n data bits, msb first
   task automatic xfer(input logic [7:0] cmd, input int n,
                       input logic [23:0] wd, output logic [23:0] rd);
      logic r;
      rd = 24'h000000;
      sel_n_out = 1'b0;
      #800;
      for (int i = 7; i >= 0; i--) bit_x(cmd[i], r);
      for (int i = n - 1; i >= 0; i--) begin
         bit_x(wd[i], r);
         rd = {rd[22:0], r};
      end
      sel_n_out = 1'b1;
      din_out = ~din_out; // released line does not keep its bit
      #800;
   endtask
   // service: own flag cleared before the status-with-reset read
   task automatic service(output logic [15:0] st);
      logic [23:0] rd;
      irq_seen_out = 1'b0;
      xfer(8'h0c, 16, 24'h000000, rd);
      st = rd[15:0];
   endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        core_clk;  // master clock
   logic        reset_n;   // active low reset
   logic [23:0] cur;       // current word
   logic [23:0] volt;      // voltage word
   logic        valid;     // sample strobe
   logic        sclk, sel_n, din, dout, dout_oe, irq_n, irq_oe;
   logic        zx, route, tick, irq_w, seen;
   logic [23:0] rd;        // last frame data
   logic [15:0] st;        // last status
   logic [7:0]  tcode;     // sensor code
   int          error_cnt, check_count;
   // reset table: address, length, value
   logic [5:0]  ra [9] = '{6'h09, 6'h0a, 6'h0b, 6'h20, 6'h21, 6'h22,
                           6'h24, 6'h26, 6'h3f};
   int          rn [9] = '{16, 16, 16, 8, 8, 24, 24, 8, 8};
   logic [23:0] re [9] = '{0, 0, 0, 24'hff, 24'hff, 0, 0, 0, 0};
   always #50 core_clk = ~core_clk;
   pdi_peak_irq pdi_peak_irq_i (.core_clk_in(core_clk),
      .reset_n_in(reset_n), .serial_clk_in(sclk),
      .serial_sel_n_in(sel_n), .serial_din_in(din),
      .current_sample_in(cur), .voltage_sample_in(volt),
      .sample_valid_in(valid), .temp_code_in(tcode),
      .serial_dout_out(dout), .serial_dout_oe_out(dout_oe),
      .irq_n_out(irq_n), .irq_oe_out(irq_oe),
      .line_zero_crossing_out(zx), .temp_route_out(route),
      .mod_sample_tick_out(tick));
   pdi_host_model pdi_host_model_i (.dout_in(dout), .dout_oe_in(dout_oe),
      .irq_n_in(irq_n), .irq_oe_in(irq_oe), .sclk_out(sclk),
      .sel_n_out(sel_n), .din_out(din), .irq_level_out(irq_w),
      .irq_seen_out(seen));
   // compare and count
   task chk(input logic [23:0] g, input logic [23:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask
   task rdc(input logic [5:0] a, input int n, input logic [23:0] e);
      pdi_host_model_i.xfer({2'b00, a}, n, 24'h000000, rd);
      chk(rd, e);
   endtask
   task wr(input logic [5:0] a, input int n, input logic [23:0] v);
      pdi_host_model_i.xfer({2'b10, a}, n, v, rd);
   endtask
   // one strobe, then let flags and irq settle
   task smp(input logic [23:0] c, input logic [23:0] v);
      @(posedge core_clk) #1;
      cur = c;
      volt = v;
      valid = 1'b1;
      @(posedge core_clk) #1;
      valid = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   task conclude;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog, well past the expected run
   initial begin
      #3000000;
      error_cnt++;
      conclude();
   end
   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      cur = 24'h0;
      volt = 24'h0;
      tcode = 8'h3b;
      valid = 1'b0;
      error_cnt = 0;
      check_count = 0;
      repeat (2) @(posedge core_clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge core_clk);
      for (int k = 0; k < 9; k++) rdc(ra[k], rn[k], re[k]);
      wr(6'h20, 8, 24'h10);
      wr(6'h21, 8, 24'h10);
      // voltage doubled upper byte equal to level: no event
      smp(24'h0a0000, 24'h080000);
      rdc(6'h0b, 16, 24'h0100);
      chk(irq_w, 1'b1);
      smp(24'h000000, 24'hf70000);
      rdc(6'h0b, 16, 24'h0300);
      smp(24'h050000, 24'h010000);
      chk(zx, 1'b1);
      rdc(6'h24, 24, 24'h120000);
      rdc(6'h23, 24, 24'h0a0000);
      rdc(6'h22, 24, 24'h000000);
      wr(6'h0a, 16, 24'h0300);
      chk(irq_w, 1'b0);
      chk(seen, 1'b1);
      pdi_host_model_i.service(st);
      chk(st, 16'h0300);
      chk(irq_w, 1'b1);
      smp(24'h0a0000, 24'h010000);
      chk(irq_w, 1'b0);
      // voltage event lands during the status data
      fork
         pdi_host_model_i.service(st);
         begin
            #10400;
            chk(irq_w, 1'b1);
            smp(24'h000000, 24'hf00000);
            chk(irq_w, 1'b1);
         end
      join
      chk(st, 16'h0100);
      chk(irq_w, 1'b0);
      rdc(6'h0b, 16, 24'h0200);
      pdi_host_model_i.service(st);
      chk(st, 16'h0200);
      chk(irq_w, 1'b1);
      // voltage record through its clearing alias
      rdc(6'h25, 24, 24'h200000);
      rdc(6'h24, 24, 24'h000000);
      wr(6'h09, 16, 24'h0020);
      wr(6'h0a, 16, 24'h0020);
      smp(24'h000000, 24'h010000);
      chk(route, 1'b1);
      // code moves mid conversion: only the final one may land
      tcode = 8'hc4;
      repeat (100) @(posedge core_clk);
      #1;
      chk(route, 1'b0);
      rdc(6'h26, 8, 24'h0000c4);
      rdc(6'h0b, 16, 24'h0020);
      chk(irq_w, 1'b0);
      rdc(6'h09, 16, 24'h0000);
      conclude();
   end
endmodule
`default_nettype wire
